// ### rtl/mtpcap_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "mtpcap_consts.svh"


module mtpcap_top (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Access request from the application or debug side.
  input wire logic reqValid,
  input var mtpcap_pkg::mtpcap_req_t reqData,
  output logic reqReady,
  // Access answer.
  output logic rspValid,
  output var mtpcap_pkg::mtpcap_rsp_t rspData,
  // Memory macro command port.
  output logic memValid,
  output var mtpcap_pkg::mtpcap_req_t memCmd,
  input wire logic memDone,
  input wire logic [31:0] memRdata,
  // Loaded configuration and protection state.
  output var mtpcap_pkg::mtpcap_cfg_t cfgOut,
  output logic cfgLoaded,
  output logic bootloaderDebugWriteProtect,
  output logic debugPortProtect,
  output logic appCodeLockActive,
  output logic bootloaderWriteEnable,
  // Last refused access.
  output logic denyEvent,
  output var mtpcap_pkg::mtpcap_req_t denyRecord
);

  mtpcap_pkg::mtpcap_state_t state_r;
  mtpcap_pkg::mtpcap_state_t state_nxt;
  logic [2:0] loadIdx_r;
  logic [31:0] cfgWords_r [0:7];
  logic memValid_r;
  mtpcap_pkg::mtpcap_req_t memCmd_r;
  logic rspValid_r;
  mtpcap_pkg::mtpcap_rsp_t rspData_r;
  logic cfgLoaded_r;
  logic denyEvent_r;
  mtpcap_pkg::mtpcap_req_t denyRecord_r;
  logic grant;
  logic bootProt;
  logic dbgProt;
  logic lockOn;
  logic reqTaken;
  logic [4:0] loadAddr;

  // Access decision from the loaded user word.
  mtpcap_checker u_checker (
    .userWord(cfgWords_r[`MTPCAP_LOAD_LAST]),
    .req(reqData),
    .grant(grant),
    .bootloaderDebugWriteProtect(bootProt),
    .debugPortProtect(dbgProt),
    .appCodeLockActive(lockOn)
  );

  assign reqReady = (state_r == mtpcap_pkg::ST_IDLE);
  assign reqTaken = reqValid && reqReady;
  assign loadAddr = 5'(`MTPCAP_TRIM_FIRST + {2'h0, loadIdx_r});

  // Sequencer: load eight info words, then serve accesses.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      mtpcap_pkg::ST_LOAD_REQ: begin
        state_nxt = mtpcap_pkg::ST_LOAD_WAIT;
      end
      mtpcap_pkg::ST_LOAD_WAIT: begin
        if (memDone) begin
          state_nxt = (loadIdx_r == `MTPCAP_LOAD_LAST) ? mtpcap_pkg::ST_IDLE
                                                       : mtpcap_pkg::ST_LOAD_REQ;
        end
      end
      mtpcap_pkg::ST_IDLE: begin
        if (reqTaken && grant) begin
          state_nxt = mtpcap_pkg::ST_ACCESS;
        end
      end
      mtpcap_pkg::ST_ACCESS: begin
        if (memDone) begin
          state_nxt = mtpcap_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = mtpcap_pkg::ST_LOAD_REQ;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= mtpcap_pkg::ST_LOAD_REQ;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Load word counter.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      loadIdx_r <= 3'h0;
    end else if (state_r == mtpcap_pkg::ST_LOAD_WAIT && memDone) begin
      loadIdx_r <= 3'(loadIdx_r + 3'h1);
    end
  end

  // Memory command: loader reads, or a granted access only.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      memValid_r <= 1'b0;
      memCmd_r <= '0;
    end else begin
      unique case (state_r)
        mtpcap_pkg::ST_LOAD_REQ: begin
          memValid_r <= 1'b1;
          memCmd_r.write <= 1'b0;
          memCmd_r.debug <= 1'b0;
          memCmd_r.space <= mtpcap_pkg::SPACE_INFO;
          memCmd_r.addr <= {8'h00, loadAddr};
          memCmd_r.wdata <= 32'h0000_0000;
        end
        mtpcap_pkg::ST_IDLE: begin
          if (reqTaken && grant) begin
            memValid_r <= 1'b1;
            memCmd_r <= reqData;
          end
        end
        default: begin
          if (memDone) begin
            memValid_r <= 1'b0;
          end
        end
      endcase
    end
  end

  // Configuration registers filled from the information block.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        cfgWords_r[i] <= `MTPCAP_CFG_RESET;
      end
    end else if (state_r == mtpcap_pkg::ST_LOAD_WAIT && memDone) begin
      cfgWords_r[loadIdx_r] <= memRdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfgLoaded_r <= 1'b0;
    end else if (state_r == mtpcap_pkg::ST_LOAD_WAIT && memDone
                 && loadIdx_r == `MTPCAP_LOAD_LAST) begin
      cfgLoaded_r <= 1'b1;
    end
  end

  // Answer: a refusal right away, a granted access when memory finishes.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rspValid_r <= 1'b0;
      rspData_r <= '0;
    end else begin
      rspValid_r <= 1'b0;
      if (state_r == mtpcap_pkg::ST_IDLE && reqTaken && !grant) begin
        rspValid_r <= 1'b1;
        rspData_r.denied <= 1'b1;
        rspData_r.rdata <= 32'h0000_0000;
      end else if (state_r == mtpcap_pkg::ST_ACCESS && memDone) begin
        rspValid_r <= 1'b1;
        rspData_r.denied <= 1'b0;
        rspData_r.rdata <= memCmd_r.write ? 32'h0000_0000 : memRdata;
      end
    end
  end

  // Record of the most recent refused access.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      denyEvent_r <= 1'b0;
      denyRecord_r <= '0;
    end else begin
      denyEvent_r <= reqTaken && !grant;
      if (reqTaken && !grant) begin
        denyRecord_r <= reqData;
      end
    end
  end

  generate
    for (genvar t = 0; t < 4; t++) begin : g_trim
      assign cfgOut.trim[t] = cfgWords_r[t];
    end
    for (genvar d = 0; d < 3; d++) begin : g_id
      assign cfgOut.id[d] = cfgWords_r[d + 4];
    end
  endgenerate
  assign cfgOut.user = cfgWords_r[`MTPCAP_LOAD_LAST];

  assign memValid = memValid_r;
  assign memCmd = memCmd_r;
  assign rspValid = rspValid_r;
  assign rspData = rspData_r;
  assign cfgLoaded = cfgLoaded_r;
  assign bootloaderDebugWriteProtect = bootProt;
  assign debugPortProtect = dbgProt;
  assign appCodeLockActive = lockOn;
  assign bootloaderWriteEnable = !dbgProt && !bootProt;
  assign denyEvent = denyEvent_r;
  assign denyRecord = denyRecord_r;

endmodule // mtpcap_top

`default_nettype wire

// ### rtl/mtpcap_consts.svh
`ifndef MTPCAP_CONSTS_SVH
`define MTPCAP_CONSTS_SVH

`define MTPCAP_TRIM_FIRST 5'h18
`define MTPCAP_TRIM_LAST 5'h1B
`define MTPCAP_ID_FIRST 5'h1C
`define MTPCAP_ID_LAST 5'h1E
`define MTPCAP_USER_ADDR 5'h1F
`define MTPCAP_LOAD_LAST 3'h7
`define MTPCAP_BOOT_HI 23
`define MTPCAP_BOOT_LO 16
`define MTPCAP_DBG_HI 15
`define MTPCAP_DBG_LO 8
`define MTPCAP_LOCK_HI 7
`define MTPCAP_LOCK_LO 0
`define MTPCAP_BOOT_CODE 8'h55
`define MTPCAP_DBG_CODE 8'hAA
`define MTPCAP_LOCK_CODE 8'h33
`define MTPCAP_SECTOR_HI 12
`define MTPCAP_SECTOR_LO 10
`define MTPCAP_BOOT_SECTOR 3'h7
`define MTPCAP_CFG_RESET 32'h0000_0000

`endif

// ### rtl/mtpcap_pkg.sv
package mtpcap_pkg;

  typedef enum logic [1:0] {
    SPACE_MAIN = 2'h0,
    SPACE_INFO = 2'h1,
    SPACE_EEPROM = 2'h2,
    SPACE_NONE = 2'h3
  } mtpcap_space_t;

  typedef struct packed {
    logic write;
    logic debug;
    mtpcap_space_t space;
    logic [12:0] addr;
    logic [31:0] wdata;
  } mtpcap_req_t;

  typedef struct packed {
    logic denied;
    logic [31:0] rdata;
  } mtpcap_rsp_t;

  typedef struct packed {
    logic [3:0][31:0] trim;
    logic [2:0][31:0] id;
    logic [31:0] user;
  } mtpcap_cfg_t;

  typedef enum logic [2:0] {
    ST_LOAD_REQ = 3'h0,
    ST_LOAD_WAIT = 3'h1,
    ST_IDLE = 3'h3,
    ST_ACCESS = 3'h2
  } mtpcap_state_t;

endpackage

// ### rtl/mtpcap_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "mtpcap_consts.svh"

module mtpcap_checker (
  // Loaded protection word.
  input wire logic [31:0] userWord,
  // Access under test.
  input var mtpcap_pkg::mtpcap_req_t req,
  // Decision and decoded protection state.
  output logic grant,
  output logic bootloaderDebugWriteProtect,
  output logic debugPortProtect,
  output logic appCodeLockActive
);

  function automatic logic codeMatch(input logic [7:0] field, input logic [7:0] code);
    codeMatch = (field == code);
  endfunction

  logic isBoot;
  logic isTrim;
  logic isUser;

  assign bootloaderDebugWriteProtect =
    codeMatch(userWord[`MTPCAP_BOOT_HI:`MTPCAP_BOOT_LO], `MTPCAP_BOOT_CODE);
  assign debugPortProtect =
    codeMatch(userWord[`MTPCAP_DBG_HI:`MTPCAP_DBG_LO], `MTPCAP_DBG_CODE);
  assign appCodeLockActive =
    codeMatch(userWord[`MTPCAP_LOCK_HI:`MTPCAP_LOCK_LO], `MTPCAP_LOCK_CODE);

  assign isBoot = (req.addr[`MTPCAP_SECTOR_HI:`MTPCAP_SECTOR_LO] == `MTPCAP_BOOT_SECTOR);
  assign isTrim = (req.addr[4:0] >= `MTPCAP_TRIM_FIRST) && (req.addr[4:0] <= `MTPCAP_TRIM_LAST);
  assign isUser = (req.addr[4:0] == `MTPCAP_USER_ADDR);

  always_comb begin
    grant = 1'b0;
    unique case (req.space)
      mtpcap_pkg::SPACE_MAIN: begin
        if (isBoot) begin
          grant = req.debug ? (!debugPortProtect && !bootloaderDebugWriteProtect)
                            : !req.write;
        end else begin
          grant = req.debug ? !debugPortProtect : !appCodeLockActive;
        end
      end
      mtpcap_pkg::SPACE_INFO: begin
        grant = req.debug ? !debugPortProtect : (!req.write || !(isTrim || isUser));
      end
      mtpcap_pkg::SPACE_EEPROM: begin
        grant = req.debug ? !debugPortProtect : 1'b1;
      end
      default: begin
        grant = 1'b0;
      end
    endcase
  end

endmodule // mtpcap_checker

`default_nettype wire

// ### testbench/mtpcap_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module mtpcap_mem_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Command from the design.
  input wire logic memValid,
  input var mtpcap_pkg::mtpcap_req_t memCmd,
  output logic memDone,
  output logic [31:0] memRdata,
  // Stored user word, answer delay and write count.
  input wire logic [31:0] userWord,
  input wire logic [1:0] lat,
  output var int wrCount
);
  logic [1:0] cnt;
  // Data is valid only with the done pulse and is scrambled afterwards.
  always_ff @(posedge clk) begin
    memDone <= 1'b0;
    memRdata <= ~memRdata;
    if (!rst_n) begin
      cnt <= 2'h0;
      wrCount <= 0;
    end else if (memValid && !memDone) begin
      cnt <= cnt + 2'h1;
      if (cnt == lat) begin
        cnt <= 2'h0;
        memDone <= 1'b1;
        wrCount <= wrCount + memCmd.write;
        memRdata <= {8'hA5, 9'h0, memCmd.space, memCmd.addr};
        if (memCmd.space == mtpcap_pkg::SPACE_INFO && memCmd.addr[4:0] == 5'h1F) begin
          memRdata <= userWord;
        end
      end
    end
  end
endmodule // mtpcap_mem_model
`default_nettype wire

// ### testbench/mtpcap_top_chk.sv
`timescale 1ns/10ps
`default_nettype none
module mtpcap_top_chk (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Watched ports.
  input wire logic rspValid,
  input var mtpcap_pkg::mtpcap_rsp_t rspData,
  input wire logic memValid,
  input var mtpcap_pkg::mtpcap_req_t memCmd,
  input wire logic memDone,
  input wire logic [31:0] memRdata,
  input var mtpcap_pkg::mtpcap_cfg_t cfgOut,
  input wire logic cfgLoaded,
  input wire logic bootloaderDebugWriteProtect,
  input wire logic debugPortProtect,
  input wire logic appCodeLockActive,
  input wire logic bootloaderWriteEnable,
  input wire logic denyEvent
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_boot; bootloaderDebugWriteProtect == (cfgOut.user[23:16] == 8'h55); endproperty
  a_boot: assert property (p_boot) else $error("boot decode");
  property p_dbg; debugPortProtect == (cfgOut.user[15:8] == 8'hAA); endproperty
  a_dbg: assert property (p_dbg) else $error("debug decode");
  property p_lock; appCodeLockActive == (cfgOut.user[7:0] == 8'h33); endproperty
  a_lock: assert property (p_lock) else $error("lock decode");
  property p_bwen; bootloaderWriteEnable == !(debugPortProtect || bootloaderDebugWriteProtect);
  endproperty
  a_bwen: assert property (p_bwen) else $error("boot write enable");
  property p_start; $rose(rst_n) |-> ##[1:2] memValid && memCmd.addr[4:0] == 5'h18; endproperty
  a_start: assert property (p_start) else $error("load start");
  property p_user; memDone && memValid && !cfgLoaded && memCmd.addr[4:0] == 5'h1F
    |=> cfgLoaded && cfgOut.user == $past(memRdata); endproperty
  a_user: assert property (p_user) else $error("user word load");
  property p_deny; denyEvent |-> rspValid && rspData.denied && !memValid; endproperty
  a_deny: assert property (p_deny) else $error("denied access");
  property p_grant; memDone && memValid && cfgLoaded |=> rspValid && !rspData.denied; endproperty
  a_grant: assert property (p_grant) else $error("granted access");
  c_deny: cover property (denyEvent);
  c_load: cover property ($rose(cfgLoaded));
  c_grant: cover property (rspValid && !rspData.denied);
endmodule // mtpcap_top_chk
bind mtpcap_top mtpcap_top_chk chk (
  .clk(clk), .rst_n(rst_n), .rspValid(rspValid), .rspData(rspData), .memValid(memValid),
  .memCmd(memCmd), .memDone(memDone), .memRdata(memRdata), .cfgOut(cfgOut),
  .cfgLoaded(cfgLoaded), .bootloaderDebugWriteProtect(bootloaderDebugWriteProtect),
  .debugPortProtect(debugPortProtect), .appCodeLockActive(appCodeLockActive),
  .bootloaderWriteEnable(bootloaderWriteEnable), .denyEvent(denyEvent)
);
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin nChecks++; if ((g) !== (e)) begin failCount++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb;
  logic clk, rst_n, reqValid, reqReady, rspValid, memValid, memDone, cfgLoaded, denyEvent;
  logic bootloaderDebugWriteProtect, debugPortProtect, appCodeLockActive, bootloaderWriteEnable;
  logic [31:0] memRdata, userWord;
  logic [1:0] lat;
  int wrCount, failCount, nChecks;
  mtpcap_pkg::mtpcap_req_t reqData, memCmd, denyRecord;
  mtpcap_pkg::mtpcap_rsp_t rspData;
  mtpcap_pkg::mtpcap_cfg_t cfgOut;
  logic [31:0] cfgs [6] = '{32'h0, 32'h0055AA33, 32'h0054AB32, 32'h00550000, 32'h33, 32'hAA00};
  logic [14:0] locs [10] = '{15'h0000, 15'h1BFF, 15'h1C00, 15'h2018, 15'h201B, 15'h201C,
    15'h201F, 15'h2005, 15'h41FF, 15'h6000};
  mtpcap_top dut (
    .clk(clk), .rst_n(rst_n), .reqValid(reqValid), .reqData(reqData), .reqReady(reqReady),
    .rspValid(rspValid), .rspData(rspData), .memValid(memValid), .memCmd(memCmd),
    .memDone(memDone), .memRdata(memRdata), .cfgOut(cfgOut), .cfgLoaded(cfgLoaded),
    .bootloaderDebugWriteProtect(bootloaderDebugWriteProtect),
    .debugPortProtect(debugPortProtect), .appCodeLockActive(appCodeLockActive),
    .bootloaderWriteEnable(bootloaderWriteEnable), .denyEvent(denyEvent),
    .denyRecord(denyRecord)
  );
  mtpcap_mem_model mem (
    .clk(clk), .rst_n(rst_n), .memValid(memValid), .memCmd(memCmd), .memDone(memDone),
    .memRdata(memRdata), .userWord(userWord), .lat(lat), .wrCount(wrCount)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic allow(logic [31:0] u, logic [14:0] l, logic w, logic d);
    logic dp, bp, lk;
    dp = u[15:8] == 8'hAA;
    bp = u[23:16] == 8'h55;
    lk = u[7:0] == 8'h33;
    case (l[14:13])
      2'h0: allow = l[12:10] == 3'h7 ? (d ? !dp && !bp : !w) : (d ? !dp : !lk);
      2'h1: allow = d ? !dp : !(w && (l[4:0] inside {[5'h18:5'h1B], 5'h1F}));
      2'h2: allow = !(d && dp);
      default: allow = 1'b0;
    endcase
  endfunction
  task automatic access(logic [14:0] l, logic w, logic d);
    int n, w0;
    logic ok;
    logic [31:0] ex;
    ok = allow(userWord, l, w, d);
    w0 = wrCount;
    ex = (!ok || w) ? 32'h0 : (l == 15'h201F) ? userWord : {8'hA5, 9'h0, l};
    reqData = {w, d, l, 17'h0, l};
    reqValid = 1'b1;
    for (n = 0; n < 50 && reqReady !== 1'b1; n++) @(posedge clk) #1;
    `CHK("ready", 1'b1, reqReady)
    @(posedge clk) #1;
    reqValid = 1'b0;
    for (n = 0; n < 50 && rspValid !== 1'b1; n++) @(posedge clk) #1;
    `CHK("rsp valid", 1'b1, rspValid)
    `CHK("denied", !ok, rspData.denied)
    `CHK("rdata", ex, rspData.rdata)
    `CHK("deny event", !ok, denyEvent)
    `CHK("writes", w0 + (ok && w), wrCount)
    if (!ok) `CHK("deny record", reqData, denyRecord)
    @(posedge clk) #1;
  endtask
  task automatic boot(logic [31:0] u, logic [1:0] lt);
    int n;
    rst_n = 1'b0;
    userWord = u;
    lat = lt;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    for (n = 0; n < 200 && cfgLoaded !== 1'b1; n++) @(posedge clk) #1;
    `CHK("loaded", 1'b1, cfgLoaded)
    `CHK("boot wen", u[15:8] != 8'hAA && u[23:16] != 8'h55, bootloaderWriteEnable)
    for (n = 0; n < 4; n++) `CHK("trim", {8'hA5, 9'h0, 2'h1, 8'h0, 5'(24 + n)}, cfgOut.trim[n])
    for (n = 0; n < 3; n++) `CHK("id", {8'hA5, 9'h0, 2'h1, 8'h0, 5'(28 + n)}, cfgOut.id[n])
    `CHK("user", u, cfgOut.user)
    `CHK("boot", u[23:16] == 8'h55, bootloaderDebugWriteProtect)
    `CHK("debug", u[15:8] == 8'hAA, debugPortProtect)
    `CHK("lock", u[7:0] == 8'h33, appCodeLockActive)
  endtask
  task automatic testDone;
    if (failCount == 0 && nChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #200000;
    failCount++;
    testDone();
  end
  initial begin
    rst_n = 1'b0;
    reqValid = 1'b0;
    reqData = '0;
    userWord = '0;
    lat = 2'h0;
    failCount = 0;
    nChecks = 0;
    @(posedge clk) #1;
    for (int c = 0; c < 6; c++) begin
      boot(cfgs[c], 2'(c % 3));
      for (int i = 0; i < 40; i++) access(locs[i / 4], i[0], i[1]);
    end
    testDone();
  end
endmodule // tb
`default_nettype wire
